// ---- rtl/tape_ctl_pkg.sv ----
// Constants for the tape load and on-line control block
package tape_ctl_pkg;
  localparam int unsigned CLK_PERIOD_NS       = 4;
  // Durations are not given; plain defaults chosen in microseconds, the pulse in nanoseconds
  localparam int unsigned ENTRY_DELAY_US      = 2;
  localparam int unsigned RELAY_DELAY_US      = 1;
  localparam int unsigned OFFSET_TIME_US      = 2;
  localparam int unsigned PULSE_TIME_NS       = 40;
  localparam int unsigned FAULT_WAIT_US       = 1;
  localparam int unsigned ENTRY_DELAY_CYC = ENTRY_DELAY_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned RELAY_DELAY_CYC = RELAY_DELAY_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned OFFSET_CYC      = OFFSET_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned PULSE_CYC       = PULSE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned FAULT_WAIT_CYC  = FAULT_WAIT_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned DEBOUNCE_CYC    = 8;
  localparam int unsigned TMR_W           = 12;
  localparam logic        RST_VAL         = 1'b0;

  typedef enum logic [6:0] {
    LD_IDLE    = 7'b000_0001,
    LD_TENSION = 7'b000_0010,
    LD_ENTRY   = 7'b000_0100,
    LD_COLUMN  = 7'b000_1000,
    LD_ADVANCE = 7'b001_0000,
    LD_OFFSET  = 7'b010_0000,
    LD_FAULT   = 7'b100_0000
  } load_state_e;
endpackage : tape_ctl_pkg

// ---- rtl/interlock_debounce.sv ----
// Synchroniser and debouncer for the column interlock
`timescale 1ns/1ps
module interlock_debounce
  import tape_ctl_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  input  wire logic i_raw,
  output logic      o_stable
);
  logic                  sync1_ff;
  logic                  sync2_ff;
  logic [TMR_W-1:0]      cnt_ff;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1_ff <= RST_VAL;
      sync2_ff <= RST_VAL;
    end else if (i_ce) begin
      sync1_ff <= i_raw;
      sync2_ff <= sync1_ff;
    end
  end

  // Output follows only after the level holds steady
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_ff   <= '0;
      o_stable <= RST_VAL;
    end else if (i_ce) begin
      if (sync2_ff == o_stable) begin
        cnt_ff <= '0;
      end else if (cnt_ff == TMR_W'(DEBOUNCE_CYC - 1)) begin
        cnt_ff   <= '0;
        o_stable <= sync2_ff;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end
endmodule : interlock_debounce

// ---- rtl/tape_load_online_control.sv ----
// Load, on-line and ready control of a vacuum-column tape unit
`timescale 1ns/1ps
// Function
// - Motion high whenever forward or reverse run command is asserted.
// - Ready only while tape loaded and not rewinding.
// - Alternate ready true once load completed, sequencer idle and not rewinding.
// - Ready-offline: loaded, not rewinding, on-line flip-flop clear.
// - Ready-online: loaded, not rewinding, on-line flip-flop set.
// - Qualify term is on-line, ready and selected; gates commands.
// - On-line flip-flop kept; commands accepted only while set.
// - First load flop tensions tape; second drives tape to start marker.
// - Start reel motors once load-ready condition reached.
// - Load delay times when tape may enter the columns.
// - Load fault aborts load if column switches fail to close.
// - Momentary relay pulse during load sequence.
// - Load-once flop set at load completion, held as record.
// - Load-then-online flop launches combined load and on-line.
// - Combined operation energises relay, delayed for remote load.
// - Combined operation times take-up servo offset.
// - Strobe at end of combined operation sets on-line flop.
// - Maintenance motion asserted while switch held that direction.
// - Power reset holds logic until supplies safe, and on failure.
// - Interlock is relay and switches closed, debounced.
// - Reset button or interlock loss clears on-line and ready.
module tape_load_online_control
  import tape_ctl_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  input  wire logic i_power_ok,
  input  wire logic i_load_btn,
  input  wire logic i_load_online_btn,
  input  wire logic i_remote_load,
  input  wire logic i_online_btn,
  input  wire logic i_reset_btn,
  input  wire logic i_switches_closed,
  input  wire logic i_at_start_marker,
  input  wire logic i_rewinding,
  input  wire logic i_select,
  input  wire logic i_sync_forward_cmd,
  input  wire logic i_sync_reverse_cmd,
  input  wire logic i_maint_fwd_sw,
  input  wire logic i_maint_rev_sw,
  output logic      o_tension_load,
  output logic      o_advance_to_start,
  output logic      o_reel_start_ok,
  output logic      o_interlock_relay,
  output logic      o_relay_pulse,
  output logic      o_servo_offset,
  output logic      o_load_fault,
  output logic      o_loaded_once,
  output logic      o_online,
  output logic      o_online_set_strobe,
  output logic      o_ready,
  output logic      o_unit_ready_alt,
  output logic      o_ready_offline,
  output logic      o_ready_online,
  output logic      o_command_qualify,
  output logic      o_forward_run,
  output logic      o_reverse_run,
  output logic      o_motion,
  output logic      o_maint_forward,
  output logic      o_maint_reverse,
  output logic      o_power_up_reset
);
  import tape_ctl_pkg::*;

  localparam int unsigned NPIN = 13;

  load_state_e           state_ff;
  load_state_e           nxt_state;
  logic [TMR_W-1:0]      tmr_ff;
  logic [NPIN-1:0]       pin_raw;
  logic [NPIN-1:0]       pin_s1_ff;
  logic [NPIN-1:0]       pin_s2_ff;
  logic                  pwr_rst_ff;
  logic                  column_interlock;
  logic                  top_level_clear;
  logic                  load_then_online_ff;
  logic                  relay_hold_ff;
  logic                  load_btn_d_ff;
  logic                  lol_btn_d_ff;
  logic                  onl_btn_d_ff;
  logic                  loaded;
  logic                  fwd_in, rev_in, sel_in, rwd_in, bot_in;
  logic                  start_load;

  // Every pin except clock, reset and clock enable passes two flops before use
  assign pin_raw = {i_maint_rev_sw, i_power_ok, i_load_btn,
                    i_load_online_btn, i_remote_load,
                    i_online_btn, i_reset_btn, i_at_start_marker, i_rewinding,
                    i_select, i_sync_forward_cmd, i_sync_reverse_cmd,
                    i_maint_fwd_sw};

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else if (i_ce) begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  assign fwd_in = pin_s2_ff[2];
  assign rev_in = pin_s2_ff[1];
  assign sel_in = pin_s2_ff[3];
  assign rwd_in = pin_s2_ff[4];
  assign bot_in = pin_s2_ff[5];

  // Relay contact and switches both closed, then debounced
  interlock_debounce u_column_interlock (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_ce     (i_ce),
    .i_raw    (i_switches_closed & o_interlock_relay),
    .o_stable (column_interlock)
  );

  // Power reset held while supplies are low
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pwr_rst_ff <= 1'b1;
    end else if (i_ce) begin
      pwr_rst_ff <= ~pin_s2_ff[11];
    end
  end
  assign o_power_up_reset = pwr_rst_ff;

  // Interlock loss only counts once the load has completed (load-once record set)
  assign top_level_clear = pwr_rst_ff | pin_s2_ff[6]
                         | (loaded & ~column_interlock);
  assign loaded = o_loaded_once;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      load_btn_d_ff <= 1'b0;
      lol_btn_d_ff  <= 1'b0;
      onl_btn_d_ff  <= 1'b0;
    end else if (i_ce) begin
      load_btn_d_ff <= pin_s2_ff[10];
      lol_btn_d_ff  <= pin_s2_ff[9];
      onl_btn_d_ff  <= pin_s2_ff[7];
    end
  end

  assign start_load = (pin_s2_ff[10] & ~load_btn_d_ff)
                    | (pin_s2_ff[9] & ~lol_btn_d_ff);

  // Load sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      LD_IDLE:    if (start_load && !loaded) nxt_state = LD_TENSION;
      LD_TENSION: if (tmr_ff == '0) nxt_state = LD_ENTRY;
      LD_ENTRY:   if (tmr_ff == '0) nxt_state = LD_COLUMN;
      LD_COLUMN: begin
        if (column_interlock) nxt_state = LD_ADVANCE;
        else if (tmr_ff == '0) nxt_state = LD_FAULT;
      end
      LD_ADVANCE: begin
        if (bot_in && load_then_online_ff) nxt_state = LD_OFFSET;
        else if (bot_in) nxt_state = LD_IDLE;
      end
      LD_OFFSET:  if (tmr_ff == '0) nxt_state = LD_IDLE;
      LD_FAULT:   if (start_load) nxt_state = LD_TENSION;
      default:    nxt_state = LD_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || (i_ce && (pwr_rst_ff || pin_s2_ff[6]))) begin
      state_ff <= LD_IDLE;
      tmr_ff   <= '0;
    end else if (i_ce) begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff) begin
        case (nxt_state)
          LD_TENSION: tmr_ff <= TMR_W'(PULSE_CYC - 1);
          LD_ENTRY: begin
            if (load_then_online_ff && pin_s2_ff[8])
              tmr_ff <= TMR_W'(ENTRY_DELAY_CYC + RELAY_DELAY_CYC - 1);
            else
              tmr_ff <= TMR_W'(ENTRY_DELAY_CYC - 1);
          end
          LD_COLUMN:  tmr_ff <= TMR_W'(FAULT_WAIT_CYC - 1);
          LD_OFFSET:  tmr_ff <= TMR_W'(OFFSET_CYC - 1);
          default:    tmr_ff <= '0;
        endcase
      end else if (tmr_ff != '0) begin
        tmr_ff <= tmr_ff - 1'b1;
      end
    end
  end

  // Load outputs and load fault
  always_ff @(posedge i_clk) begin
    if (i_rst || (i_ce && pwr_rst_ff)) begin
      o_tension_load     <= 1'b0;
      o_advance_to_start <= 1'b0;
      o_reel_start_ok    <= 1'b0;
      o_relay_pulse      <= 1'b0;
      o_load_fault       <= 1'b0;
      o_servo_offset     <= 1'b0;
    end else if (i_ce) begin
      o_tension_load     <= nxt_state inside {LD_TENSION, LD_ENTRY,
                                              LD_COLUMN};
      o_advance_to_start <= nxt_state == LD_ADVANCE;
      o_reel_start_ok    <= nxt_state inside {LD_COLUMN,
                                              LD_ADVANCE};
      o_relay_pulse      <= nxt_state == LD_TENSION;
      o_servo_offset     <= nxt_state == LD_OFFSET;
      if (nxt_state == LD_FAULT)
        o_load_fault <= 1'b1;
      else if (start_load)
        o_load_fault <= 1'b0;
    end
  end

  // Relay held from column entry on; delayed for remote combined load
  always_ff @(posedge i_clk) begin
    if (i_rst || (i_ce && pwr_rst_ff)) begin
      relay_hold_ff     <= 1'b0;
      o_interlock_relay <= 1'b0;
    end else if (i_ce) begin
      if (nxt_state == LD_FAULT || pin_s2_ff[6])
        relay_hold_ff <= 1'b0;
      else if (nxt_state == LD_COLUMN)
        relay_hold_ff <= 1'b1;
      o_interlock_relay <= (nxt_state == LD_TENSION) | relay_hold_ff
                         | (nxt_state == LD_COLUMN);
    end
  end

  // Combined load-then-online flop
  always_ff @(posedge i_clk) begin
    if (i_rst || (i_ce && (pwr_rst_ff || pin_s2_ff[6]))) begin
      load_then_online_ff <= 1'b0;
    end else if (i_ce) begin
      if (pin_s2_ff[9] && !lol_btn_d_ff)
        load_then_online_ff <= 1'b1;
      else if (state_ff == LD_OFFSET && nxt_state == LD_IDLE)
        load_then_online_ff <= 1'b0;
      else if (nxt_state == LD_FAULT)
        load_then_online_ff <= 1'b0;
    end
  end

  // Load-once record and on-line flop
  always_ff @(posedge i_clk) begin
    if (i_rst || (i_ce && pwr_rst_ff)) begin
      o_loaded_once       <= 1'b0;
      o_online            <= 1'b0;
      o_online_set_strobe <= 1'b0;
    end else if (i_ce) begin
      o_online_set_strobe <= state_ff == LD_OFFSET && nxt_state == LD_IDLE;
      if (state_ff == LD_ADVANCE && nxt_state != LD_ADVANCE)
        o_loaded_once <= 1'b1;
      else if (top_level_clear)
        o_loaded_once <= 1'b0;
      if (o_online_set_strobe)
        o_online <= 1'b1;
      else if (top_level_clear)
        o_online <= 1'b0;
      else if (pin_s2_ff[7] && !onl_btn_d_ff)
        o_online <= ~o_online;
    end
  end

  // Ready terms and command gating
  always_ff @(posedge i_clk) begin
    if (i_rst || (i_ce && pwr_rst_ff)) begin
      o_ready           <= 1'b0;
      o_unit_ready_alt  <= 1'b0;
      o_ready_offline   <= 1'b0;
      o_ready_online    <= 1'b0;
      o_command_qualify <= 1'b0;
    end else if (i_ce) begin
      o_ready           <= loaded & ~rwd_in & ~top_level_clear;
      o_unit_ready_alt  <= loaded & ~rwd_in & (state_ff == LD_IDLE);
      o_ready_offline   <= loaded & ~rwd_in & ~o_online;
      o_ready_online    <= loaded & ~rwd_in & o_online;
      o_command_qualify <= o_online & o_ready & sel_in;
    end
  end

  // Run commands accepted only while qualified; reverse has its own line
  always_ff @(posedge i_clk) begin
    if (i_rst || (i_ce && pwr_rst_ff)) begin
      o_forward_run   <= 1'b0;
      o_reverse_run   <= 1'b0;
      o_motion        <= 1'b0;
      o_maint_forward <= 1'b0;
      o_maint_reverse <= 1'b0;
    end else if (i_ce) begin
      o_forward_run   <= o_command_qualify & fwd_in & ~rev_in;
      o_reverse_run   <= o_command_qualify & rev_in & ~fwd_in;
      o_motion        <= (o_command_qualify & fwd_in & ~rev_in)
                       | (o_command_qualify & rev_in & ~fwd_in);
      // Both directions held at once is ignored
      o_maint_forward <= pin_s2_ff[0] & ~pin_s2_ff[12];
      o_maint_reverse <= pin_s2_ff[12] & ~pin_s2_ff[0];
    end
  end

  AST_MOTION: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce |=> (o_motion == (o_forward_run | o_reverse_run)))
    else $error("motion does not follow run commands");
  AST_READY_SPLIT: assert property (@(posedge i_clk) disable iff (i_rst)
    !(o_ready_online && o_ready_offline))
    else $error("ready online and offline together");
  AST_QUAL: assert property (@(posedge i_clk) disable iff (i_rst)
    o_forward_run |-> $past(o_command_qualify))
    else $error("forward run without qualification");
  AST_QUAL_ONL: assert property (@(posedge i_clk) disable iff (i_rst)
    o_command_qualify |-> $past(o_online))
    else $error("qualify without online");
  AST_LOADFLOPS: assert property (@(posedge i_clk) disable iff (i_rst)
    !(o_tension_load && o_advance_to_start))
    else $error("both load flops set");
  AST_STROBE: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_online_set_strobe && i_ce && !pwr_rst_ff) |=> o_online)
    else $error("strobe did not set online");
  AST_PWR: assert property (@(posedge i_clk) disable iff (i_rst)
    (pwr_rst_ff && i_ce) |=> !o_online && !o_loaded_once && !o_ready)
    else $error("power reset did not clear");
  AST_FAULT: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_ff == LD_FAULT) |-> o_load_fault || !$past(i_ce))
    else $error("fault state without fault flag");
endmodule : tape_load_online_control

// ---- tb/tape_far_side.sv ----
// Transport model: column switches and start marker answering the block
`timescale 1ns/1ps
module tape_far_side #(
  parameter int unsigned COL_CYC = 20,
  parameter int unsigned ADV_CYC = 30
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_slow,
  input  wire logic i_block,
  input  wire logic i_reel_start_ok,
  input  wire logic i_advance,
  output logic      o_switches_closed,
  output logic      o_at_start_marker
);
  int unsigned cnt_ff;
  int unsigned lim;
  logic        reel_q_ff;

  // Slow mode stretches every mechanical delay fourfold
  assign lim = i_slow ? 4 : 1;

  always_ff @(posedge i_clk) begin
    reel_q_ff <= i_reel_start_ok;
    if (i_rst || i_block) begin
      cnt_ff            <= 0;
      o_switches_closed <= 1'h0;
      o_at_start_marker <= 1'h0;
    end else if (i_reel_start_ok && !reel_q_ff) begin
      // New load: tape leaves the marker
      cnt_ff            <= 0;
      o_at_start_marker <= 1'h0;
    end else if (i_advance && !o_at_start_marker) begin
      cnt_ff <= cnt_ff + 1;
      if (cnt_ff >= ADV_CYC * lim) begin
        o_at_start_marker <= 1'h1;
        cnt_ff            <= 0;
      end
    end else if (i_reel_start_ok && !o_switches_closed) begin
      cnt_ff <= cnt_ff + 1;
      if (cnt_ff >= COL_CYC * lim) begin
        o_switches_closed <= 1'h1;
        cnt_ff            <= 0;
      end
    end
  end
endmodule : tape_far_side

// ---- tb/tape_load_online_control_tb.sv ----
// Self-checking bench for the tape load and on-line control block
`timescale 1ns/1ps
module tape_load_online_control_tb;
  import tape_ctl_pkg::*;
  logic i_clk = 1'h0, i_rst = 1'h1, i_ce = 1'h1, i_power_ok = 1'h1;
  logic [3:0] btn = 4'h0;
  logic i_remote_load = 1'h0, i_rewinding = 1'h0, i_select = 1'h0;
  logic i_sync_forward_cmd = 1'h0, i_sync_reverse_cmd = 1'h0;
  logic i_maint_fwd_sw = 1'h0, i_maint_rev_sw = 1'h0;
  logic block = 1'h0, slow = 1'h0, i_switches_closed, i_at_start_marker;
  logic o_tension_load, o_advance_to_start, o_reel_start_ok;
  logic o_interlock_relay, o_relay_pulse, o_servo_offset, o_load_fault;
  logic o_loaded_once, o_online, o_online_set_strobe, o_ready;
  logic o_unit_ready_alt, o_ready_offline, o_ready_online;
  logic o_command_qualify, o_forward_run, o_reverse_run, o_motion;
  logic o_maint_forward, o_maint_reverse, o_power_up_reset;
  logic [8:0] obs;
  int fails = 0, compares = 0, cycles = 0;

  assign obs = {o_tension_load, o_reel_start_ok, o_advance_to_start,
                o_loaded_once, o_load_fault, o_servo_offset,
                o_online_set_strobe, o_online, o_interlock_relay};

  tape_load_online_control u_tape_load_online_control (
    .i_clk, .i_rst, .i_ce, .i_power_ok, .i_load_btn(btn[0]),
    .i_load_online_btn(btn[3]), .i_remote_load, .i_online_btn(btn[1]),
    .i_reset_btn(btn[2]), .i_switches_closed, .i_at_start_marker,
    .i_rewinding, .i_select, .i_sync_forward_cmd, .i_sync_reverse_cmd,
    .i_maint_fwd_sw, .i_maint_rev_sw, .o_tension_load, .o_advance_to_start,
    .o_reel_start_ok, .o_interlock_relay, .o_relay_pulse, .o_servo_offset,
    .o_load_fault, .o_loaded_once, .o_online, .o_online_set_strobe,
    .o_ready, .o_unit_ready_alt, .o_ready_offline, .o_ready_online,
    .o_command_qualify, .o_forward_run, .o_reverse_run, .o_motion,
    .o_maint_forward, .o_maint_reverse, .o_power_up_reset);

  tape_far_side u_tape_far_side (
    .i_clk, .i_rst, .i_slow(slow), .i_block(block),
    .i_reel_start_ok(o_reel_start_ok), .i_advance(o_advance_to_start),
    .o_switches_closed(i_switches_closed),
    .o_at_start_marker(i_at_start_marker));

  always #2 i_clk = ~i_clk;

  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  // Whole run is near 3000 cycles
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask : cyc

  task automatic press(input int b);
    @(posedge i_clk) btn[b] <= 1'h1;
    cyc(3);
    @(posedge i_clk) btn[b] <= 1'h0;
    #1;
  endtask : press

  task automatic wait_bit(input int b, input logic v, input int max,
                          output int n);
    n = 0;
    while (obs[b] !== v && n < max) begin
      cyc(1);
      n++;
    end
    chk(obs[b], v, "status wait ran out");
  endtask : wait_bit

  initial begin
    int n;
    cyc(15);
    @(posedge i_clk) i_rst <= 1'h0;
    cyc(8);
    chk(o_power_up_reset, 1'h0, "power reset stuck");
    chk(o_ready, 1'h0, "ready after reset");
    chk(o_online, 1'h0, "online after reset");
    press(0);
    wait_bit(8, 1'h1, 20, n);
    chk(o_relay_pulse, 1'h1, "no relay pulse");
    wait_bit(7, 1'h1, 1000, n);
    chk(n >= ENTRY_DELAY_CYC - 10, 1'h1, "column entry early");
    wait_bit(6, 1'h1, 200, n);
    cyc(2);
    chk(o_tension_load, 1'h0, "tension held");
    wait_bit(5, 1'h1, 400, n);
    cyc(2);
    chk(o_ready, 1'h1, "not ready");
    chk(o_unit_ready_alt, 1'h1, "alt ready low");
    chk(o_ready_offline, 1'h1, "ready offline low");
    chk(o_ready_online, 1'h0, "ready online high");
    @(posedge i_clk) i_select <= 1'h1;
    i_sync_forward_cmd <= 1'h1;
    cyc(6);
    chk(o_forward_run, 1'h0, "run while offline");
    chk(o_command_qualify, 1'h0, "qualify offline");
    @(posedge i_clk) i_sync_forward_cmd <= 1'h0;
    press(1);
    cyc(8);
    chk(o_online, 1'h1, "online not set");
    chk(o_ready_online, 1'h1, "ready online low");
    chk(o_ready_offline, 1'h0, "ready offline high");
    chk(o_command_qualify, 1'h1, "qualify low");
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk) i_sync_forward_cmd <= k[0];
      i_sync_reverse_cmd <= k[1];
      i_maint_fwd_sw <= k[0];
      i_maint_rev_sw <= k[1];
      cyc(6);
      chk(o_forward_run, k == 1, "forward run");
      chk(o_reverse_run, k == 2, "reverse run");
      chk(o_motion, k == 1 || k == 2, "motion");
      chk(o_maint_forward, k == 1, "maint forward");
      chk(o_maint_reverse, k == 2, "maint reverse");
    end
    @(posedge i_clk) i_select <= 1'h0;
    i_sync_forward_cmd <= 1'h1;
    i_sync_reverse_cmd <= 1'h0;
    cyc(6);
    chk(o_motion, 1'h0, "motion unselected");
    @(posedge i_clk) i_select <= 1'h1;
    i_sync_forward_cmd <= 1'h0;
    i_rewinding <= 1'h1;
    cyc(6);
    chk(o_ready, 1'h0, "ready in rewind");
    chk(o_unit_ready_alt, 1'h0, "alt ready in rewind");
    chk(o_ready_online, 1'h0, "ready online in rewind");
    chk(o_command_qualify, 1'h0, "qualify in rewind");
    @(posedge i_clk) i_rewinding <= 1'h0;
    block <= 1'h1;
    cyc(30);
    chk(o_online, 1'h0, "online after interlock loss");
    chk(o_ready, 1'h0, "ready after interlock loss");
    press(2);
    cyc(8);
    chk(o_loaded_once, 1'h0, "loaded record kept");
    chk(o_interlock_relay, 1'h0, "relay kept after reset");
    // Columns stay open, so this load must fail
    press(0);
    wait_bit(4, 1'h1, 2000, n);
    cyc(2);
    chk(o_tension_load, 1'h0, "tension after fault");
    chk(o_advance_to_start, 1'h0, "advance after fault");
    @(posedge i_clk) block <= 1'h0;
    slow <= 1'h1;
    i_remote_load <= 1'h1;
    press(3);
    // Past the point where an undelayed load would close the relay
    cyc(PULSE_CYC + ENTRY_DELAY_CYC + 2);
    chk(o_interlock_relay, 1'h0, "relay not delayed");
    wait_bit(0, 1'h1, 400, n);
    chk(o_load_fault, 1'h0, "fault kept");
    wait_bit(3, 1'h1, 4000, n);
    wait_bit(3, 1'h0, OFFSET_CYC + 20, n);
    chk(n >= OFFSET_CYC - 5, 1'h1, "offset short");
    wait_bit(2, 1'h1, 20, n);
    wait_bit(1, 1'h1, 4, n);
    chk(o_loaded_once, 1'h1, "combined load record");
    @(posedge i_clk) i_power_ok <= 1'h0;
    cyc(6);
    chk(o_power_up_reset, 1'h1, "no power reset");
    chk(o_online, 1'h0, "online in power reset");
    chk(o_loaded_once, 1'h0, "loaded in power reset");
    chk(o_ready, 1'h0, "ready in power reset");
    @(posedge i_clk) i_power_ok <= 1'h1;
    cyc(8);
    chk(o_power_up_reset, 1'h0, "power reset held");
    end_sim();
  end
endmodule : tape_load_online_control_tb
